/* File: include/abtr_consts.svh */
`ifndef ABTR_CONSTS_SVH
`define ABTR_CONSTS_SVH
`define ABTR_ADDR_ABE 2'h0
`define ABTR_ADDR_BTD 2'h1
`define ABTR_ADDR_IST 2'h2
`define ABTR_ADDR_IMK 2'h3
`define ABTR_ABE_RST 8'h00
`define ABTR_BTD_RST 8'h81
`define ABTR_BTD_WMASK 8'h9F
`define ABTR_IMK_RST 8'h00
`define ABTR_DRV_RST 4'h2
`define ABTR_BIT_OVEN 7
`define ABTR_BIT_UVEN 6
`define ABTR_BIT_MEAS 5
`define ABTR_BIT_SLCP 4
`define ABTR_BIT_CRTM 3
`define ABTR_BIT_TMPS 2
`define ABTR_BIT_EFFC 1
`define ABTR_BIT_PATH 0
`define ABTR_BIT_HID 3
`define ABTR_BIT_LOD 2
`define ABTR_BIT_BNCH 1
`define ABTR_BIT_GDD 0
`define ABTR_IRQ_OV 0
`define ABTR_IRQ_UV 1
`define ABTR_IRQ_DONE 2
`endif

/* File: include/abtr_pkg.sv */
package abtr_pkg;
  typedef struct packed {
    logic ov_detect_enable;
    logic uv_detect_enable;
    logic eff_meas_start;
    logic slope_comp_bypass;
    logic current_meas_enable;
    logic temp_sensor_enable;
    logic eff_circuit_enable;
    logic signal_path_enable;
  } abtr_analog_en_s;
  typedef struct packed {
    logic high_side_drv_en;
    logic low_side_drv_en;
    logic switch_node_float;
    logic first_gp_pin_bench;
  } abtr_drv_ctl_s;
  typedef enum logic [1:0] {
    ABTR_MEAS_IDLE = 2'b01,
    ABTR_MEAS_BUSY = 2'b10
  } abtr_meas_e;
endpackage

/* File: verilog/abtr_regs.sv */
// Overview of operation
// - overvoltage detect enable gates overvoltage comparison; off ignores threshold.
// - undervoltage detect enable gates undervoltage comparison; off ignores threshold.
// - writing 1 starts efficiency measurement; bit reads 0 when idle.
// - slope compensation bypass 1 disables compensation, 0 enables it.
// - current measurement enable powers peak current measurement circuitry.
// - temperature sensor active only while its enable bit is 1.
// - efficiency circuit enable powers relative efficiency circuitry.
// - signal path enable turns on voltage control signal chain.
// - global driver disable resets to 1; software clears it.
// - global disable forces both drives low and floats switch node.
// - high side disable bit turns off the high side driver.
// - low side disable bit turns off the low side driver.
// - bench test enable routes buffered analog test output to pin.
// - bench bits six and five read zero, writes ignored.
// - overvoltage above threshold while enabled sets sticky flag.
// - undervoltage below threshold while enabled sets sticky flag.
//
// Local design decisions: the plain strobed port and the register addresses.
`include "abtr_consts.svh"
module abtr_regs #(
  parameter int THR_W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // analog sense
  input wire logic [THR_W-1:0] vout_sense_i,
  input wire logic [THR_W-1:0] ov_threshold_setting_i,
  input wire logic [THR_W-1:0] uv_threshold_setting_i,
  input wire logic eff_meas_done_i,
  // analog controls
  output abtr_pkg::abtr_analog_en_s analog_en_o,
  output abtr_pkg::abtr_drv_ctl_s drv_ctl_o,
  // interrupt
  output logic irq_o
);
  logic rst_sync1;
  logic rst_b;
  logic [7:0] abe;
  logic [7:0] btd;
  logic [7:0] imk;
  logic [2:0] ist;
  logic [7:0] next_rdata;
  logic ov_hit;
  logic uv_hit;
  logic ist_rd;
  abtr_pkg::abtr_meas_e meas_state;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync1 <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_b <= rst_sync1;
    end
  end

  // start bit is stored but unused; its readback and the start output reflect the measurement state machine
  always_ff @(posedge ref_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      abe <= `ABTR_ABE_RST;
    end else if (wr_i && addr_i == `ABTR_ADDR_ABE) begin
      abe <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      meas_state <= abtr_pkg::ABTR_MEAS_IDLE;
    end else begin
      case (meas_state)
        abtr_pkg::ABTR_MEAS_IDLE: begin
          if (wr_i && addr_i == `ABTR_ADDR_ABE && wdata_i[`ABTR_BIT_MEAS]) begin
            meas_state <= abtr_pkg::ABTR_MEAS_BUSY;
          end
        end
        abtr_pkg::ABTR_MEAS_BUSY: begin
          if (eff_meas_done_i) begin
            meas_state <= abtr_pkg::ABTR_MEAS_IDLE;
          end
        end
        default: meas_state <= abtr_pkg::ABTR_MEAS_IDLE;
      endcase
    end
  end

  // reserved bits 7 and 4 stay writable storage, 6 and 5 are not stored
  always_ff @(posedge ref_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      btd <= `ABTR_BTD_RST;
    end else if (wr_i && addr_i == `ABTR_ADDR_BTD) begin
      btd <= wdata_i & `ABTR_BTD_WMASK;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      imk <= `ABTR_IMK_RST;
    end else if (wr_i && addr_i == `ABTR_ADDR_IMK) begin
      imk <= wdata_i;
    end
  end

  assign ov_hit = abe[`ABTR_BIT_OVEN] && (vout_sense_i > ov_threshold_setting_i);
  assign uv_hit = abe[`ABTR_BIT_UVEN] && (vout_sense_i < uv_threshold_setting_i);
  assign ist_rd = rd_i && addr_i == `ABTR_ADDR_IST;

  // read clears, but a same-cycle event still wins
  always_ff @(posedge ref_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      ist <= 3'h0;
    end else begin
      ist[`ABTR_IRQ_OV] <= ov_hit | (ist[`ABTR_IRQ_OV] & ~ist_rd);
      ist[`ABTR_IRQ_UV] <= uv_hit | (ist[`ABTR_IRQ_UV] & ~ist_rd);
      ist[`ABTR_IRQ_DONE] <= (meas_state == abtr_pkg::ABTR_MEAS_BUSY && eff_meas_done_i)
                             | (ist[`ABTR_IRQ_DONE] & ~ist_rd);
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (addr_i)
      `ABTR_ADDR_ABE: begin
        next_rdata = abe;
        next_rdata[`ABTR_BIT_MEAS] = (meas_state == abtr_pkg::ABTR_MEAS_BUSY);
      end
      `ABTR_ADDR_BTD: next_rdata = btd;
      `ABTR_ADDR_IST: next_rdata = {5'h00, ist};
      `ABTR_ADDR_IMK: next_rdata = imk;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? next_rdata : 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(ist & imk[2:0]);
    end
  end

  // drive outputs registered so the gates never see a decode glitch
  always_ff @(posedge ref_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      analog_en_o <= '0;
      drv_ctl_o <= `ABTR_DRV_RST;
    end else begin
      analog_en_o.ov_detect_enable <= abe[`ABTR_BIT_OVEN];
      analog_en_o.uv_detect_enable <= abe[`ABTR_BIT_UVEN];
      analog_en_o.eff_meas_start <= (meas_state == abtr_pkg::ABTR_MEAS_BUSY);
      analog_en_o.slope_comp_bypass <= abe[`ABTR_BIT_SLCP];
      analog_en_o.current_meas_enable <= abe[`ABTR_BIT_CRTM];
      analog_en_o.temp_sensor_enable <= abe[`ABTR_BIT_TMPS];
      analog_en_o.eff_circuit_enable <= abe[`ABTR_BIT_EFFC];
      analog_en_o.signal_path_enable <= abe[`ABTR_BIT_PATH];
      drv_ctl_o.high_side_drv_en <= ~btd[`ABTR_BIT_GDD] & ~btd[`ABTR_BIT_HID];
      drv_ctl_o.low_side_drv_en <= ~btd[`ABTR_BIT_GDD] & ~btd[`ABTR_BIT_LOD];
      drv_ctl_o.switch_node_float <= btd[`ABTR_BIT_GDD];
      drv_ctl_o.first_gp_pin_bench <= btd[`ABTR_BIT_BNCH];
    end
  end
endmodule

/* File: verif/abtr_regs_props.sv */
module abtr_regs_props (
  // watched ports
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic eff_meas_done_i,
  input wire abtr_pkg::abtr_analog_en_s analog_en_o,
  input wire abtr_pkg::abtr_drv_ctl_s drv_ctl_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // bit 5 left out: it shows busy state
  property p_abe; wr_i && addr_i == 2'h0 |=> ##1 {analog_en_o[7:6], analog_en_o[4:0]} ==
    {$past(wdata_i[7:6], 2), $past(wdata_i[4:0], 2)}; endproperty
  a_abe: assert property (p_abe) else $error("enables");
  property p_meas; wr_i && addr_i == 2'h0 && wdata_i[5] && !eff_meas_done_i |=> ##1
    analog_en_o.eff_meas_start; endproperty
  a_meas: assert property (p_meas) else $error("start");
  property p_hs; wr_i && addr_i == 2'h1 |=> ##1 drv_ctl_o.high_side_drv_en ==
    !($past(wdata_i[3], 2) | $past(wdata_i[0], 2)); endproperty
  a_hs: assert property (p_hs) else $error("high side");
  property p_ls; wr_i && addr_i == 2'h1 |=> ##1 drv_ctl_o.low_side_drv_en ==
    !($past(wdata_i[2], 2) | $past(wdata_i[0], 2)); endproperty
  a_ls: assert property (p_ls) else $error("low side");
  property p_flt; wr_i && addr_i == 2'h1 |=> ##1 drv_ctl_o.switch_node_float ==
    $past(wdata_i[0], 2); endproperty
  a_flt: assert property (p_flt) else $error("float");
  property p_bch; wr_i && addr_i == 2'h1 |=> ##1 drv_ctl_o.first_gp_pin_bench ==
    $past(wdata_i[1], 2); endproperty
  a_bch: assert property (p_bch) else $error("bench");
  property p_off; drv_ctl_o.switch_node_float |-> !drv_ctl_o.high_side_drv_en &&
    !drv_ctl_o.low_side_drv_en; endproperty
  a_off: assert property (p_off) else $error("forced off");
  property p_un; rd_i && addr_i == 2'h1 |=> rdata_o[6:5] == 2'h0; endproperty
  a_un: assert property (p_un) else $error("unimpl");
  property p_rst; $rose(rst_b_i) |-> drv_ctl_o.switch_node_float [*3]; endproperty
  a_rst: assert property (p_rst) else $error("reset");
endmodule
bind abtr_regs abtr_regs_props u_props (.*);

/* File: verif/abtr_regs_tb.sv */
module abtr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, eff_meas_done_i = 0, irq_o;
  logic [1:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o, vout_sense_i = 8'h50;
  logic [7:0] ov_threshold_setting_i = 8'h80, uv_threshold_setting_i = 8'h10;
  abtr_pkg::abtr_analog_en_s analog_en_o;
  abtr_pkg::abtr_drv_ctl_s drv_ctl_o;
  int num_errors = 0, n_compared = 0;
  // addr, write, readback, enables, drivers; reserved bits kept at 1 and 0
  logic [29:0] rows [6] = '{{2'h0, 8'hDF, 8'hDF, 8'hDF, 4'h2}, {2'h1, 8'hE3, 8'h83, 8'hDF, 4'h3},
    {2'h1, 8'h82, 8'h82, 8'hDF, 4'hD}, {2'h1, 8'h88, 8'h88, 8'hDF, 4'h4},
    {2'h1, 8'h84, 8'h84, 8'hDF, 4'h8}, {2'h0, 8'h00, 8'h00, 8'h00, 4'h8}};
  always #5 ref_clk_i = ~ref_clk_i;
  abtr_regs dut (.*);
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t %h %h", $time, s, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge ref_clk_i);
    wr_i <= 0;
  endtask
  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge ref_clk_i);
    rd_i <= 0;
    #1;
    chk(rdata_o, e);
  endtask
  // vout excursion held three cycles, then back between thresholds
  task ev(input logic [7:0] en, input logic [7:0] v);
    wr(2'h0, en);
    @(posedge ref_clk_i);
    vout_sense_i <= v;
    repeat (3) @(posedge ref_clk_i);
    vout_sense_i <= 8'h50;
    tick(2);
  endtask
  task finish_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1;
    tick(5);
    chk({4'h0, drv_ctl_o}, 8'h02);
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h81);
    foreach (rows[i]) begin
      wr(rows[i][29:28], rows[i][27:20]);
      rd(rows[i][29:28], rows[i][19:12]);
      chk(analog_en_o, rows[i][11:4]);
      chk({4'h0, drv_ctl_o}, {4'h0, rows[i][3:0]});
    end
    wr(2'h3, 8'h07);
    wr(2'h0, 8'h20);
    rd(2'h0, 8'h20);
    chk(analog_en_o, 8'h20);
    @(posedge ref_clk_i);
    eff_meas_done_i <= 1;
    @(posedge ref_clk_i);
    eff_meas_done_i <= 0;
    tick(3);
    rd(2'h0, 8'h00);
    chk({7'h0, irq_o}, 8'h01);
    rd(2'h2, 8'h04);
    tick(2);
    chk({7'h0, irq_o}, 8'h00);
    rd(2'h2, 8'h00);
    wr(2'h3, 8'h00);
    ev(8'h00, 8'hF0);
    rd(2'h2, 8'h00);
    ev(8'h00, 8'h05);
    rd(2'h2, 8'h00);
    ev(8'h80, 8'hF0);
    chk({7'h0, irq_o}, 8'h00);
    rd(2'h2, 8'h01);
    ev(8'h40, 8'h05);
    rd(2'h2, 8'h02);
    finish_test();
  end
endmodule
